// ---- tb/bo_assist_test.sv ----
`timescale 1ns/1ps
module bo_assist_test;
  logic mclk = 1'h0;
  logic resetn = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [4:0] fstall = 5'h00;
  logic tx_ready;
  logic [7:0] rdata;
  logic [4:0] out_redir;
  logic [4:0] in_redir;
  bo_pkg::bo_rx_t rx;
  bo_pkg::bo_in_t in_ev;
  bo_pkg::bo_tx_t tx;
  int n_fail = 0;
  int comparisons = 0;

  always #10 mclk = ~mclk;

  bo_assist u_dut (.i_mclk(mclk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rx(rx), .i_forced_stall(fstall),
    .i_in(in_ev), .i_tx_ready(tx_ready), .o_tx(tx), .o_out_redirect(out_redir),
    .o_in_redirect(in_redir));

  bo_host u_host (.i_mclk(mclk), .i_tx(tx), .o_rx(rx), .o_in(in_ev),
    .o_tx_ready(tx_ready));

  // ****************
  // Helpers
  // ****************
  task automatic end_of_test;
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge mclk);
    wr <= 1'h0;
  endtask : wr_reg

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'h1;
    @(posedge mclk);
    rd <= 1'h0;
    #1;
    chk(what, rdata, exp);
  endtask : rd_chk

  // Flags are read, then cleared so the next scenario starts clean
  task automatic flags(input logic [7:0] st, input logic [7:0] ctl);
    repeat (2) @(posedge mclk);
    rd_chk("status", bo_pkg::ADDR_STATUS, st);
    rd_chk("control", bo_pkg::ADDR_CONTROL, ctl);
    wr_reg(bo_pkg::ADDR_STATUS, 8'h3F);
  endtask : flags

  task automatic area_chk(input logic [7:0] base);
    wr_reg(bo_pkg::ADDR_CBW_PTR, 8'h00);
    for (int i = 0; i < 32; i++) begin
      rd_chk("cmd_byte", bo_pkg::ADDR_CBW_DATA, base + 8'(i % 31));
    end
    // Thirty-two reads wrap once past the last byte, so the pointer sits at 1
    rd_chk("cmd_ptr", bo_pkg::ADDR_CBW_PTR, 8'h01);
  endtask : area_chk

  task automatic in_chk(input logic slow, input logic ack);
    logic [7:0] got [13];
    int n;
    int last_at;
    u_host.take_in(3'h2, slow, ack, got, n, last_at);
    chk("in_count", 8'(n), 8'h0D);
    chk("in_last", 8'(last_at), 8'h0C);
    for (int i = 0; i < 13; i++) chk("in_byte", got[i], 8'hA0 + 8'(i));
  endtask : in_chk

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    rd_chk("status", bo_pkg::ADDR_STATUS, 8'h00);
    rd_chk("control", bo_pkg::ADDR_CONTROL, 8'h00);
    rd_chk("unmapped", 8'h7F, 8'h00);
    chk("out_redir", {3'h0, out_redir}, 8'h00);
    wr_reg(bo_pkg::ADDR_CONFIG, 8'h04);
    rd_chk("config", bo_pkg::ADDR_CONFIG, 8'h04);
  endtask : t_reset

  task automatic t_capture;
    wr_reg(bo_pkg::ADDR_CONTROL, 8'h03);
    @(posedge mclk);
    #1;
    chk("out_redir", {3'h0, out_redir}, 8'h04);
    chk("in_redir", {3'h0, in_redir}, 8'h04);
    u_host.send_out(3'h2, 31, 8'h40, 1'h1, 1'h0);
    flags(8'h01, 8'h00);
    chk("out_redir", {3'h0, out_redir}, 8'h00);
    area_chk(8'h40);
  endtask : t_capture

  // Too short and too long must both leave the stored command intact
  task automatic t_length;
    for (int k = 0; k < 2; k++) begin
      wr_reg(bo_pkg::ADDR_CONTROL, 8'h03);
      u_host.send_out(3'h2, 30 + 2 * k, 8'h80, 1'h1, 1'h0);
      flags(8'h02, 8'h00);
    end
    area_chk(8'h40);
  endtask : t_length

  task automatic t_stall;
    @(posedge mclk);
    fstall <= 5'h04;
    wr_reg(bo_pkg::ADDR_CONTROL, 8'h03);
    u_host.send_out(3'h2, 0, 8'h00, 1'h1, 1'h1);
    flags(8'h04, 8'h00);
    fstall <= 5'h00;
  endtask : t_stall

  task automatic t_tran_err;
    wr_reg(bo_pkg::ADDR_CONTROL, 8'h03);
    u_host.send_out(3'h2, 31, 8'hC0, 1'h0, 1'h0);
    repeat (2) @(posedge mclk);
    wr_reg(bo_pkg::ADDR_STATUS, 8'h37);
    rd_chk("status", bo_pkg::ADDR_STATUS, 8'h08);
    flags(8'h08, 8'h03);
    u_host.send_out(3'h1, 31, 8'h00, 1'h1, 1'h0);
    flags(8'h00, 8'h03);
  endtask : t_tran_err

  task automatic t_status;
    wr_reg(bo_pkg::ADDR_CSW_PTR, 8'h00);
    for (int i = 0; i < 13; i++) wr_reg(bo_pkg::ADDR_CSW_DOOR, 8'hA0 + 8'(i));
    rd_chk("door_ptr", bo_pkg::ADDR_CSW_PTR, 8'h00);
    rd_chk("door_read", bo_pkg::ADDR_CSW_DOOR, 8'h00);
    wr_reg(bo_pkg::ADDR_CONTROL, 8'h02);
    in_chk(1'h1, 1'h1);
    flags(8'h10, 8'h01);
  endtask : t_status

  task automatic t_retry;
    wr_reg(bo_pkg::ADDR_CONTROL, 8'h02);
    in_chk(1'h0, 1'h0);
    flags(8'h20, 8'h03);
    in_chk(1'h0, 1'h1);
    flags(8'h10, 8'h01);
    wr_reg(bo_pkg::ADDR_CONTROL, 8'h02);
    in_chk(1'h0, 1'h0);
    flags(8'h20, 8'h03);
    u_host.send_out(3'h2, 31, 8'h60, 1'h1, 1'h0);
    flags(8'h01, 8'h00);
    area_chk(8'h60);
  endtask : t_retry

  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'h1;
    t_reset();
    t_capture();
    t_length();
    t_stall();
    t_tran_err();
    t_status();
    t_retry();
    end_of_test();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
endmodule : bo_assist_test

// ---- tb/bo_host.sv ----
`timescale 1ns/1ps
module bo_host (
  input wire logic i_mclk,
  input wire bo_pkg::bo_tx_t i_tx,
  output bo_pkg::bo_rx_t o_rx,
  output bo_pkg::bo_in_t o_in,
  output logic o_tx_ready
);
  initial begin
    o_rx = '0;
    o_in = '0;
    o_tx_ready = 1'h0;
  end

  // ****************
  // OUT packets
  // ****************
  // End beat data is the inverted last byte; the idle beat after it inverts again and shows the last byte itself
  task automatic send_out(input logic [2:0] ep, input int n, input logic [7:0] base,
    input logic ok, input logic stall);
    for (int i = 0; i < n; i++) begin
      @(posedge i_mclk);
      o_rx <= {1'h1, ep, base + 8'(i), 3'h0};
    end
    @(posedge i_mclk);
    o_rx <= {1'h0, ep, ~o_rx.data, !stall, ok, stall};
    @(posedge i_mclk);
    o_rx <= {1'h0, ep, ~o_rx.data, 3'h0};
  endtask : send_out

  // ****************
  // IN packets
  // ****************
  // A slow host toggles ready so every byte must be held by the sender
  task automatic take_in(input logic [2:0] ep, input logic slow, input logic ack,
    output logic [7:0] got [13], output int n, output int last_at);
    n = 0;
    last_at = -1;
    @(posedge i_mclk);
    o_in <= {1'h1, 1'h0, 1'h0, ep};
    o_tx_ready <= !slow;
    for (int c = 0; c < 80 && last_at < 0; c++) begin
      @(posedge i_mclk);
      o_in.token <= 1'h0;
      if (i_tx.valid === 1'h1 && o_tx_ready) begin
        if (n < 13) got[n] = i_tx.data;
        if (i_tx.last === 1'h1) last_at = n;
        n++;
      end
      o_tx_ready <= slow ? ~o_tx_ready : 1'h1;
    end
    @(posedge i_mclk);
    o_tx_ready <= 1'h0;
    o_in <= {1'h0, ack, !ack, ep};
    @(posedge i_mclk);
    o_in <= {1'h0, 1'h0, 1'h0, ep};
  endtask : take_in
endmodule : bo_host

// ---- verilog/bo_area.sv ----
`timescale 1ns/1ps
module bo_area #(
  parameter int unsigned DEPTH = 31,
  parameter bit STAGED = 1'b1
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_wr_en,
  input wire logic [4:0] i_wr_idx,
  input wire logic [7:0] i_wr_data,
  input wire logic i_commit,
  input wire logic [4:0] i_rd_idx,
  output logic [7:0] o_rd_data
);

  // ****************************************************************
  // Entries
  // ****************************************************************
  // Staged areas keep the last good packet visible until commit
  wire [DEPTH-1:0][7:0] vis_w;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      logic [7:0] stage_r;
      logic [7:0] stage_nxt;
      logic [7:0] vis_r;
      logic [7:0] vis_nxt;
      always_comb begin
        stage_nxt = stage_r;
        if (i_wr_en && (i_wr_idx == 5'(g))) begin
          stage_nxt = i_wr_data;
        end
        vis_nxt = vis_r;
        if (!STAGED || i_commit) begin
          vis_nxt = stage_nxt;
        end
      end
      always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
          stage_r <= 8'h00;
          vis_r <= 8'h00;
        end else begin
          stage_r <= stage_nxt;
          vis_r <= vis_nxt;
        end
      end
      assign vis_w[g] = vis_r;
    end
  endgenerate

  assign o_rd_data = (i_rd_idx < 5'(DEPTH)) ? vis_w[i_rd_idx] : 8'h00;

endmodule : bo_area

// ---- verilog/bo_assist.sv ----
`timescale 1ns/1ps
// Contract
// - Endpoint enable bit turns on command capture for that OUT endpoint.
// - Enabled endpoint with command mode set treats OUT data as a command.
// - Exactly 31 bytes: store, flag complete, clear both mode bits.
// - Other lengths: discard, flag length error, clear both mode bits.
// - Forced stall answered with STALL: flag error, clear both mode bits.
// - Transaction error: discard, flag it, mode bits unchanged.
// - Captured command bytes are readable through a memory read port.
// - Endpoint enable bit turns on status send for that IN endpoint.
// - Status mode set: answer IN with 13 bytes from status area.
// - ACK after status: flag complete, clear status mode, set command mode.
// - No ACK: flag error, keep status mode, set command mode.
// - Both modes active: resend status on IN, accept command on OUT.
// - Status area is written through a memory write door.
// - Active wrapper traffic uses wrapper areas, not the endpoint FIFO.
module bo_assist (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire bo_pkg::bo_rx_t i_rx,
  input wire logic [4:0] i_forced_stall,
  input wire bo_pkg::bo_in_t i_in,
  input wire logic i_tx_ready,
  output bo_pkg::bo_tx_t o_tx,
  output logic [4:0] o_out_redirect,
  output logic [4:0] o_in_redirect
);

  // ****************************************************************
  // Registers and decode
  // ****************************************************************
  logic [4:0] cfg_r, cfg_nxt;
  logic [1:0] ctl_r, ctl_nxt;
  logic [5:0] sts_r, sts_nxt;
  logic [4:0] cbw_ptr_r, cbw_ptr_nxt;
  logic [4:0] csw_ptr_r, csw_ptr_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [4:0] out_redir_r, out_redir_nxt;
  logic [4:0] in_redir_r, in_redir_nxt;
  bo_pkg::bo_tx_state_t state_r, state_nxt;
  logic [3:0] idx_r, idx_nxt;
  bo_pkg::bo_tx_t tx_r, tx_nxt;

  logic rx_ep_ok, in_ep_ok, cap_on, in_on;
  logic ev_cmd_ok, ev_cmd_len, ev_cmd_stall, ev_cmd_tran;
  logic ev_sts_ack, ev_sts_noack;
  logic cbw_wr, door_wr, cbw_rd_step;
  logic [5:0] sts_clr, sts_set;
  logic [7:0] cbw_rd_data, csw_rd_data;

  assign rx_ep_ok = (i_rx.ep < 3'(bo_pkg::NUM_EP));
  assign in_ep_ok = (i_in.ep < 3'(bo_pkg::NUM_EP));
  assign cap_on = rx_ep_ok && cfg_r[i_rx.ep] && ctl_r[bo_pkg::CTL_CMD_MODE];
  assign in_on = in_ep_ok && cfg_r[i_in.ep] && ctl_r[bo_pkg::CTL_STS_MODE];

  // ****************************************************************
  // Packet outcomes
  // ****************************************************************
  // Packet end is a beat of its own, after the last data byte
  assign ev_cmd_ok = cap_on && i_rx.done && i_rx.ok && (cnt_r == bo_pkg::CBW_LEN);
  assign ev_cmd_len = cap_on && i_rx.done && i_rx.ok && (cnt_r != bo_pkg::CBW_LEN);
  assign ev_cmd_tran = cap_on && i_rx.done && !i_rx.ok;
  assign ev_cmd_stall = cap_on && i_rx.stall && i_forced_stall[i_rx.ep];
  assign ev_sts_ack = (state_r == bo_pkg::TX_WAIT) && i_in.ack;
  assign ev_sts_noack = (state_r == bo_pkg::TX_WAIT) && !i_in.ack && i_in.noack;

  // Bytes past 31 are not stored; the count saturates so they still fail length
  assign cbw_wr = cap_on && i_rx.valid && (cnt_r < bo_pkg::CBW_LEN);
  assign door_wr = i_wr && (i_addr == bo_pkg::ADDR_CSW_DOOR);
  assign cbw_rd_step = i_rd && (i_addr == bo_pkg::ADDR_CBW_DATA);
  assign sts_clr = (i_wr && (i_addr == bo_pkg::ADDR_STATUS)) ? i_wdata[5:0] : 6'h00;

  always_comb begin
    sts_set = 6'h00;
    sts_set[bo_pkg::ST_CMD_CMP] = ev_cmd_ok;
    sts_set[bo_pkg::ST_CMD_LEN] = ev_cmd_len;
    sts_set[bo_pkg::ST_CMD_ERR] = ev_cmd_stall;
    sts_set[bo_pkg::ST_CMD_TRAN] = ev_cmd_tran;
    sts_set[bo_pkg::ST_STS_CMP] = ev_sts_ack;
    sts_set[bo_pkg::ST_STS_ERR] = ev_sts_noack;
  end

  always_comb begin
    cfg_nxt = cfg_r;
    ctl_nxt = ctl_r;
    cbw_ptr_nxt = cbw_ptr_r;
    csw_ptr_nxt = csw_ptr_r;
    cnt_nxt = cnt_r;
    rdata_nxt = 8'h00;
    if (i_wr) begin
      unique case (i_addr)
        bo_pkg::ADDR_CONFIG: cfg_nxt = i_wdata[4:0];
        bo_pkg::ADDR_CONTROL: ctl_nxt = i_wdata[1:0];
        bo_pkg::ADDR_CBW_PTR: cbw_ptr_nxt = i_wdata[4:0];
        bo_pkg::ADDR_CSW_PTR: csw_ptr_nxt = i_wdata[4:0];
        default: ;
      endcase
    end
    if (door_wr) begin
      csw_ptr_nxt = (csw_ptr_r >= bo_pkg::CSW_PTR_LAST) ? bo_pkg::PTR_RST : csw_ptr_r + 5'h01;
    end
    if (cbw_rd_step) begin
      cbw_ptr_nxt = (cbw_ptr_r >= bo_pkg::CBW_PTR_LAST) ? bo_pkg::PTR_RST : cbw_ptr_r + 5'h01;
    end
    if (i_rd) begin
      unique case (i_addr)
        bo_pkg::ADDR_CONFIG: rdata_nxt = {3'h0, cfg_r};
        bo_pkg::ADDR_CONTROL: rdata_nxt = {6'h00, ctl_r};
        bo_pkg::ADDR_STATUS: rdata_nxt = {2'h0, sts_r};
        bo_pkg::ADDR_CBW_PTR: rdata_nxt = {3'h0, cbw_ptr_r};
        bo_pkg::ADDR_CBW_DATA: rdata_nxt = cbw_rd_data;
        bo_pkg::ADDR_CSW_PTR: rdata_nxt = {3'h0, csw_ptr_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
    // Hardware mode updates win over a firmware write in the same cycle
    if (ev_cmd_ok || ev_cmd_len || ev_cmd_stall) begin
      ctl_nxt = 2'h0;
    end
    if (ev_sts_ack) begin
      ctl_nxt[bo_pkg::CTL_STS_MODE] = 1'b0;
    end
    if (ev_sts_ack || ev_sts_noack) begin
      ctl_nxt[bo_pkg::CTL_CMD_MODE] = 1'b1;
    end
    // Set beats clear so no event is lost
    sts_nxt = (sts_r & ~sts_clr) | sts_set;
    if (cap_on && i_rx.valid && (cnt_r < bo_pkg::CNT_SAT)) begin
      cnt_nxt = cnt_r + 6'h01;
    end
    if ((rx_ep_ok && (i_rx.done || i_rx.stall)) || !ctl_r[bo_pkg::CTL_CMD_MODE]) begin
      cnt_nxt = 6'h00;
    end
    out_redir_nxt = cfg_nxt & {5{ctl_nxt[bo_pkg::CTL_CMD_MODE]}};
    in_redir_nxt = cfg_nxt & {5{ctl_nxt[bo_pkg::CTL_STS_MODE]}};
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_r <= bo_pkg::CONFIG_RST;
      ctl_r <= bo_pkg::CONTROL_RST;
      sts_r <= bo_pkg::STATUS_RST;
      cbw_ptr_r <= bo_pkg::PTR_RST;
      csw_ptr_r <= bo_pkg::PTR_RST;
      cnt_r <= 6'h00;
      rdata_r <= 8'h00;
      out_redir_r <= 5'h00;
      in_redir_r <= 5'h00;
    end else begin
      cfg_r <= cfg_nxt;
      ctl_r <= ctl_nxt;
      sts_r <= sts_nxt;
      cbw_ptr_r <= cbw_ptr_nxt;
      csw_ptr_r <= csw_ptr_nxt;
      cnt_r <= cnt_nxt;
      rdata_r <= rdata_nxt;
      out_redir_r <= out_redir_nxt;
      in_redir_r <= in_redir_nxt;
    end
  end

  // ****************************************************************
  // Wrapper areas
  // ****************************************************************
  bo_area #(.DEPTH(bo_pkg::CBW_DEPTH), .STAGED(1'b1)) u_cbw_area (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_wr_en(cbw_wr),
    .i_wr_idx(cnt_r[4:0]),
    .i_wr_data(i_rx.data),
    .i_commit(ev_cmd_ok),
    .i_rd_idx(cbw_ptr_r),
    .o_rd_data(cbw_rd_data)
  );

  bo_area #(.DEPTH(bo_pkg::CSW_DEPTH), .STAGED(1'b0)) u_csw_area (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_wr_en(door_wr),
    .i_wr_idx(csw_ptr_r),
    .i_wr_data(i_wdata),
    .i_commit(1'b0),
    .i_rd_idx({1'b0, idx_nxt}),
    .o_rd_data(csw_rd_data)
  );

  // ****************************************************************
  // Status sender
  // ****************************************************************
  // Status mode stays set after a missing ACK, so a retried IN resends
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    tx_nxt = tx_r;
    unique case (state_r)
      bo_pkg::TX_IDLE: begin
        if (i_in.token && in_on) begin
          state_nxt = bo_pkg::TX_SEND;
          idx_nxt = 4'h0;
          tx_nxt.valid = 1'b1;
          tx_nxt.last = 1'b0;
        end
      end
      bo_pkg::TX_SEND: begin
        if (i_tx_ready) begin
          if (tx_r.last) begin
            state_nxt = bo_pkg::TX_WAIT;
            tx_nxt.valid = 1'b0;
            tx_nxt.last = 1'b0;
          end else begin
            idx_nxt = idx_r + 4'h1;
            tx_nxt.last = (idx_nxt == bo_pkg::CSW_IDX_LAST);
          end
        end
      end
      bo_pkg::TX_WAIT: begin
        if (i_in.ack || i_in.noack) begin
          state_nxt = bo_pkg::TX_IDLE;
        end
      end
    endcase
    tx_nxt.data = tx_nxt.valid ? csw_rd_data : 8'h00;
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= bo_pkg::TX_IDLE;
      idx_r <= 4'h0;
      tx_r <= '0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      tx_r <= tx_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_tx = tx_r;
  assign o_out_redirect = out_redir_r;
  assign o_in_redirect = in_redir_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic sts_evt_same;
  logic [5:0] sts_keep;
  assign sts_evt_same = ev_sts_ack || ev_sts_noack;
  assign sts_keep = sts_r & ~sts_clr;

  cmd_complete_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (ev_cmd_ok && !sts_evt_same) |=> (sts_r[bo_pkg::ST_CMD_CMP] && (ctl_r == 2'h0)))
    else $error("command complete not flagged or modes not cleared");

  cmd_length_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (ev_cmd_len && !sts_evt_same) |=>
      (sts_r[bo_pkg::ST_CMD_LEN] && !sts_r[bo_pkg::ST_CMD_CMP] && (ctl_r == 2'h0)))
    else $error("length error not flagged or modes not cleared");

  cmd_stall_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (ev_cmd_stall && !sts_evt_same) |=> (sts_r[bo_pkg::ST_CMD_ERR] && (ctl_r == 2'h0)))
    else $error("stall error not flagged or modes not cleared");

  cmd_tran_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (ev_cmd_tran && !i_wr && !sts_evt_same && !ev_cmd_stall) |=>
      (sts_r[bo_pkg::ST_CMD_TRAN] && (ctl_r == $past(ctl_r)) && (cnt_r == 6'h00)))
    else $error("transaction error changed modes or was not flagged");

  csw_length_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (state_r == bo_pkg::TX_IDLE && i_in.token && in_on) |=>
      (o_tx.valid && !o_tx.last && idx_r == 4'h0)
      ##0 (o_tx.valid && (!o_tx.last || idx_r == bo_pkg::CSW_IDX_LAST)))
    else $error("status packet did not start at byte 0");

  csw_last_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (o_tx.valid && o_tx.last) |-> (idx_r == bo_pkg::CSW_IDX_LAST))
    else $error("status packet last byte not the thirteenth");

  sts_complete_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (ev_sts_ack && !ev_cmd_ok && !ev_cmd_len && !ev_cmd_stall) |=>
      (sts_r[bo_pkg::ST_STS_CMP] && !ctl_r[bo_pkg::CTL_STS_MODE]
       && ctl_r[bo_pkg::CTL_CMD_MODE] && state_r == bo_pkg::TX_IDLE))
    else $error("status complete handling wrong");

  sts_error_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (ev_sts_noack && !i_wr && !ev_cmd_ok && !ev_cmd_len && !ev_cmd_stall) |=>
      (sts_r[bo_pkg::ST_STS_ERR] && (ctl_r == 2'h3)))
    else $error("status error handling wrong");

  flag_sticky_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    1'b1 |=> ((sts_r & $past(sts_keep)) == $past(sts_keep)))
    else $error("status flag dropped without firmware clear");

  redirect_map_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (o_out_redirect == (cfg_r & {5{ctl_r[bo_pkg::CTL_CMD_MODE]}}))
    && (o_in_redirect == (cfg_r & {5{ctl_r[bo_pkg::CTL_STS_MODE]}})))
    else $error("redirect outputs disagree with enable and mode");

  door_step_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (door_wr && csw_ptr_r < bo_pkg::CSW_PTR_LAST) |=> (csw_ptr_r == $past(csw_ptr_r) + 5'h01))
    else $error("write door pointer did not advance");

endmodule : bo_assist

// ---- verilog/bo_pkg.sv ----
package bo_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned NUM_EP = 5;
  localparam int unsigned CBW_DEPTH = 31;
  localparam int unsigned CSW_DEPTH = 13;
  localparam logic [5:0] CBW_LEN = 6'(CBW_DEPTH);
  localparam logic [5:0] CNT_SAT = 6'(CBW_DEPTH + 1);
  localparam logic [4:0] CBW_PTR_LAST = 5'(CBW_DEPTH - 1);
  localparam logic [4:0] CSW_PTR_LAST = 5'(CSW_DEPTH - 1);
  localparam logic [3:0] CSW_IDX_LAST = 4'(CSW_DEPTH - 1);

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_CBW_PTR = 8'h03;
  localparam logic [7:0] ADDR_CBW_DATA = 8'h04;
  localparam logic [7:0] ADDR_CSW_PTR = 8'h05;
  localparam logic [7:0] ADDR_CSW_DOOR = 8'h06;

  localparam int unsigned CTL_CMD_MODE = 0;
  localparam int unsigned CTL_STS_MODE = 1;

  localparam int unsigned ST_CMD_CMP = 0;
  localparam int unsigned ST_CMD_LEN = 1;
  localparam int unsigned ST_CMD_ERR = 2;
  localparam int unsigned ST_CMD_TRAN = 3;
  localparam int unsigned ST_STS_CMP = 4;
  localparam int unsigned ST_STS_ERR = 5;

  localparam logic [4:0] CONFIG_RST = 5'h00;
  localparam logic [1:0] CONTROL_RST = 2'h0;
  localparam logic [5:0] STATUS_RST = 6'h00;
  localparam logic [4:0] PTR_RST = 5'h00;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic valid;
    logic [2:0] ep;
    logic [7:0] data;
    logic done;
    logic ok;
    logic stall;
  } bo_rx_t;

  typedef struct packed {
    logic token;
    logic ack;
    logic noack;
    logic [2:0] ep;
  } bo_in_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } bo_tx_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SEND = 3'b010,
    TX_WAIT = 3'b100
  } bo_tx_state_t;

endpackage : bo_pkg
